//--- rtl/ucd_pkg.sv
// constants, types and register map of the usb charger type detection block
// assumes an ahb-lite master on the system clock and analog inputs from pins
//
// Behaviour
// [R1] voltage sources follow dp/dm enable bits
// [R2] current sinks follow dp/dm enable bits
// [R3] both current sinks never closed together
// [R4] contact source drives dp source, dm pulldown
// [R5] schmitt levels of both lines in status
// [R6] dm window comparator gives charger_detected_flag
// [R7] dp window comparator gives dedicated_port_detected_flag
// [R8] software clears control register before detection
// [R9] vbus presence shown in vbus_present_flag
// [R10] software waits out contact bounce
// [R11] software runs primary detection
// [R12] software waits settling time before reading
// [R13] software runs secondary detection
// [R14] software finally enables dp voltage source
// [R15] masked status change sets charger_event_flag
// [R16] status read clears event, set wins
// [R17] polling or usb interrupt both supported
// [R18] vbus insertion pulses key_scan_interrupt
// [R19] software provides its own delays
// [R20] second-level high status bits per line
// [R21] analog inputs pass two-flop synchronisers
package ucd_pkg;

   // ****************************************************************
   // register byte addresses
   // ****************************************************************
   localparam logic [7:0] UCD_CTRL_ADDR = 8'h00;
   localparam logic [7:0] UCD_STAT_ADDR = 8'h04;
   localparam logic [7:0] UCD_MASK_ADDR = 8'h08;
   localparam logic [7:0] UCD_EVENT_ADDR = 8'h0C;
   localparam logic [7:0] UCD_ANA_ADDR = 8'h10;

   // ****************************************************************
   // field positions and widths
   // ****************************************************************
   localparam int UCD_CTRL_W = 5;
   localparam logic [4:0] UCD_CTRL_RST = 5'h00;
   localparam int UCD_STAT_W = 4;
   localparam logic [3:0] UCD_MASK_RST = 4'h0;
   localparam int UCD_ANA_IN_W = 8;
   localparam int UCD_MASK_LSB = 4;
   localparam int UCD_EV_BIT = 0;
   localparam int UCD_VBUS_BIT = 0;
   localparam logic [1:0] UCD_HTRANS_NONSEQ = 2'h2;

   // control register bit layout
   typedef struct packed {
      logic contact_source_on;
      logic dm_current_sink_on;
      logic dp_current_sink_on;
      logic dm_voltage_source_on;
      logic dp_voltage_source_on;
   } ucd_ctrl_t;

   // analog switch enables to the pad
   typedef struct packed {
      logic dp_voltage_source_en;
      logic dm_voltage_source_en;
      logic dp_current_sink_en;
      logic dm_current_sink_en;
      logic dp_current_source_en;
      logic dm_pulldown_en;
   } ucd_sw_t;

   // raw analog results from the pad
   typedef struct packed {
      logic vbus_present;
      logic dm_high_level;
      logic dp_high_level;
      logic dedicated_port_detected;
      logic charger_detected;
      logic dm_logic_level;
      logic dp_logic_level;
      logic spare;
   } ucd_ana_t;

endpackage

//--- rtl/ucd_charger_detect.sv
// usb charger type detection control and status logic
// assumes ahb-lite single-word transfers and asynchronous analog inputs
module ucd_charger_detect
   import ucd_pkg::*;
(
   input wire logic i_sys_clk,
   input wire logic i_reset,
   input wire logic i_hsel,
   input wire logic [7:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [2:0] i_hsize,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   output logic [31:0] o_hrdata,
   output logic o_hreadyout,
   output logic o_hresp,
   input wire ucd_ana_t i_ana,
   output ucd_sw_t o_sw,
   output logic o_usb_interrupt,
   output logic o_key_scan_interrupt
);

   // ****************************************************************
   // input synchronisers
   // ****************************************************************
   ucd_ana_t ana_meta_r;
   ucd_ana_t ana_sync_r;
   ucd_ana_t ana_prev_r;

   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         ana_meta_r <= '0;
         ana_sync_r <= '0;
         ana_prev_r <= '0;
      end else begin
         ana_meta_r <= i_ana; // [R21]
         ana_sync_r <= ana_meta_r; // [R21]
         ana_prev_r <= ana_sync_r;
      end
   end

   // ****************************************************************
   // status vector
   // ****************************************************************
   logic [UCD_STAT_W-1:0] stat_now;
   logic [UCD_STAT_W-1:0] stat_prev;
   logic [5:0] stat_full;

   // bit3 dp window, bit2 dm window, bit1 dm level, bit0 dp level
   assign stat_now = {ana_sync_r.dedicated_port_detected, // [R7]
                      ana_sync_r.charger_detected, // [R6]
                      ana_sync_r.dm_logic_level, // [R5]
                      ana_sync_r.dp_logic_level}; // [R4] [R5]
   assign stat_prev = {ana_prev_r.dedicated_port_detected,
                       ana_prev_r.charger_detected,
                       ana_prev_r.dm_logic_level,
                       ana_prev_r.dp_logic_level};
   assign stat_full = {ana_sync_r.dm_high_level, ana_sync_r.dp_high_level, stat_now}; // [R20]

   // ****************************************************************
   // ahb-lite address phase capture
   // ****************************************************************
   logic ph_valid_r;
   logic ph_write_r;
   logic [7:0] ph_addr_r;
   logic take;

   assign take = i_hsel & i_hready & (i_htrans == UCD_HTRANS_NONSEQ);

   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         ph_valid_r <= 1'b0;
         ph_write_r <= 1'b0;
         ph_addr_r <= 8'h00;
      end else if (i_hready) begin
         ph_valid_r <= take;
         ph_write_r <= i_hwrite;
         ph_addr_r <= i_haddr;
      end
   end

   assign o_hreadyout = 1'b1;
   assign o_hresp = 1'b0;

   // ****************************************************************
   // register decode
   // ****************************************************************
   logic wr_ctrl;
   logic wr_mask;
   logic rd_stat;

   assign wr_ctrl = ph_valid_r & ph_write_r & (ph_addr_r == UCD_CTRL_ADDR);
   assign wr_mask = ph_valid_r & ph_write_r & (ph_addr_r == UCD_MASK_ADDR);
   assign rd_stat = take & ~i_hwrite & (i_haddr == UCD_STAT_ADDR);

   // ****************************************************************
   // control and mask registers
   // ****************************************************************
   ucd_ctrl_t ctrl_r;
   logic [UCD_STAT_W-1:0] mask_r;

   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         ctrl_r <= UCD_CTRL_RST; // [R8]
         mask_r <= UCD_MASK_RST;
      end else begin
         if (wr_ctrl) begin
            ctrl_r <= i_hwdata[UCD_CTRL_W-1:0];
         end
         if (wr_mask) begin
            mask_r <= i_hwdata[UCD_MASK_LSB+UCD_STAT_W-1:UCD_MASK_LSB];
         end
      end
   end

   // ****************************************************************
   // switch enables
   // ****************************************************************
   ucd_sw_t sw_nxt;
   ucd_sw_t sw_r;

   always_comb begin
      sw_nxt.dp_voltage_source_en = ctrl_r.dp_voltage_source_on; // [R1]
      sw_nxt.dm_voltage_source_en = ctrl_r.dm_voltage_source_on; // [R1]
      sw_nxt.dp_current_sink_en = ctrl_r.dp_current_sink_on; // [R2]
      // dp sink wins, dm sink blocked when both requested
      sw_nxt.dm_current_sink_en = ctrl_r.dm_current_sink_on &
                                  ~ctrl_r.dp_current_sink_on; // [R2] [R3]
      sw_nxt.dp_current_source_en = ctrl_r.contact_source_on; // [R4]
      sw_nxt.dm_pulldown_en = ctrl_r.contact_source_on; // [R4]
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         sw_r <= '0;
      end else begin
         sw_r <= sw_nxt;
      end
   end

   assign o_sw = sw_r;

   // ****************************************************************
   // charger event and keyboard line
   // ****************************************************************
   logic ev_set;
   logic event_r;
   logic event_nxt;
   logic key_r;

   assign ev_set = |((stat_now ^ stat_prev) & mask_r); // [R15]
   assign event_nxt = ev_set | (event_r & ~rd_stat); // [R16]

   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         event_r <= 1'b0;
         key_r <= 1'b0;
      end else begin
         event_r <= event_nxt;
         key_r <= ana_sync_r.vbus_present & ~ana_prev_r.vbus_present; // [R18]
      end
   end

   assign o_usb_interrupt = event_r; // [R17]
   assign o_key_scan_interrupt = key_r;

   // ****************************************************************
   // read data
   // ****************************************************************
   logic [31:0] rd_mux;

   assign rd_mux = (i_haddr == UCD_CTRL_ADDR) ? {27'h0, ctrl_r} :
                   (i_haddr == UCD_STAT_ADDR) ? {26'h0, stat_full} :
                   (i_haddr == UCD_MASK_ADDR) ? {24'h0, mask_r, 4'h0} :
                   (i_haddr == UCD_EVENT_ADDR) ? {31'h0, event_r} : // [R17]
                   (i_haddr == UCD_ANA_ADDR) ? {31'h0, ana_sync_r.vbus_present} : // [R9]
                   32'h0;

   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         o_hrdata <= 32'h0;
      end else if (take & ~i_hwrite) begin
         o_hrdata <= rd_mux;
      end
   end

endmodule

//--- dv/ucd_charger_detect_sva.sv
// port checker of the charger detection block
// assumes a bind onto the design top and one clock domain
module ucd_chk
   import ucd_pkg::*;
(
   input wire logic i_sys_clk,
   input wire logic i_reset,
   input wire logic i_hsel,
   input wire logic [7:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic i_hready,
   input wire ucd_ana_t i_ana,
   input wire logic o_hreadyout,
   input wire logic o_hresp,
   input wire ucd_sw_t o_sw,
   input wire logic o_usb_interrupt,
   input wire logic o_key_scan_interrupt
);
   timeunit 1ns;
   timeprecision 1ps;
   wire stat_rd = i_hsel && i_hready && i_htrans == UCD_HTRANS_NONSEQ && !i_hwrite &&
      i_haddr == UCD_STAT_ADDR;
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (i_reset);
   a_sink_excl: assert property (!(o_sw.dp_current_sink_en && o_sw.dm_current_sink_en))
      else $error("both current sinks closed");
   a_contact_pair: assert property (o_sw.dp_current_source_en == o_sw.dm_pulldown_en)
      else $error("contact source and pulldown differ");
   a_key_single: assert property (o_key_scan_interrupt |=> !o_key_scan_interrupt)
      else $error("key interrupt longer than one cycle");
   a_key_cause: assert property ($rose(i_ana.vbus_present) |-> ##[1:4] o_key_scan_interrupt)
      else $error("no key interrupt on bus voltage");
   a_event_hold: assert property (o_usb_interrupt && !stat_rd |=> o_usb_interrupt)
      else $error("event dropped without status read");
   a_event_cause: assert property ($rose(o_usb_interrupt) |->
      $past(i_ana[4:1], 3) != $past(i_ana[4:1], 4))
      else $error("event without status change");
   a_bus_okay: assert property (o_hreadyout && !o_hresp)
      else $error("bus not ready or error response");
   a_reset_quiet: assert property (disable iff (1'b0) i_reset |=>
      o_sw == '0 && !o_usb_interrupt && !o_key_scan_interrupt)
      else $error("outputs active after reset");
endmodule

bind ucd_charger_detect ucd_chk u_chk (.i_sys_clk, .i_reset, .i_hsel, .i_haddr, .i_htrans,
   .i_hwrite, .i_hready, .i_ana, .o_hreadyout, .o_hresp, .o_sw, .o_usb_interrupt,
   .o_key_scan_interrupt);

//--- dv/ucd_port_model.sv
// far side port model: analog results from switch enables
// assumes the bench picks the attached port kind
module ucd_port_model
   import ucd_pkg::*;
(
   input wire ucd_sw_t i_sw,
   input wire logic [1:0] i_kind,
   input wire logic i_vbus,
   input wire logic [1:0] i_high,
   output ucd_ana_t o_ana
);
   timeunit 1ns;
   timeprecision 1ps;
   // kinds: 0 nothing, 1 standard, 2 charging downstream, 3 dedicated
   wire contact = i_sw.dp_current_source_en && i_sw.dm_pulldown_en;
   wire primary = i_sw.dp_voltage_source_en && i_sw.dm_current_sink_en;
   wire second = i_sw.dm_voltage_source_en && i_sw.dp_current_sink_en;
   assign o_ana = {i_vbus, i_high, second && i_kind == 2'h3, primary && i_kind[1], 1'b0,
      contact && i_kind == 2'h0, 1'b0};
endmodule

//--- dv/usb_charger_type_detection_tb_top.sv
// testbench of the charger detection block
// assumes the port model on the analog side and one ahb-lite master
module usb_charger_type_detection_tb_top
   import ucd_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_sys_clk = 1'b0, i_reset = 1'b1, hsel = 1'b0, hwrite = 1'b0, vbus = 1'b0;
   logic hready, usb_int, key_int;
   logic [1:0] htrans = 2'h0, kind = 2'h0, high = 2'h0;
   logic [7:0] haddr = 8'h00;
   logic [31:0] hwdata = 32'h0, hrdata, q;
   ucd_sw_t sw;
   ucd_ana_t ana;
   int failures = 0, n_compared = 0, cyc = 0, seen = 0;
   // high, kind, control, switches, status
   logic [20:0] rows [11] = '{{2'h0, 2'h0, 5'h00, 6'h00, 6'h00}, {2'h0, 2'h0, 5'h10, 6'h03, 6'h01},
      {2'h0, 2'h1, 5'h10, 6'h03, 6'h00}, {2'h0, 2'h2, 5'h09, 6'h24, 6'h04},
      {2'h0, 2'h1, 5'h09, 6'h24, 6'h00}, {2'h0, 2'h3, 5'h06, 6'h18, 6'h08},
      {2'h0, 2'h2, 5'h06, 6'h18, 6'h00}, {2'h0, 2'h0, 5'h0C, 6'h08, 6'h00},
      {2'h1, 2'h0, 5'h01, 6'h20, 6'h10}, {2'h2, 2'h0, 5'h01, 6'h20, 6'h20},
      {2'h0, 2'h0, 5'h01, 6'h20, 6'h00}};
   ucd_charger_detect DUT (.i_sys_clk, .i_reset, .i_hsel(hsel), .i_haddr(haddr),
      .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
      .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(), .i_ana(ana),
      .o_sw(sw), .o_usb_interrupt(usb_int), .o_key_scan_interrupt(key_int));
   ucd_port_model u_port (.i_sw(sw), .i_kind(kind), .i_vbus(vbus), .i_high(high), .o_ana(ana));
   initial begin
      forever #10 i_sys_clk = ~i_sys_clk;
   end
   task automatic print_verdict;
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // every wait passes here, so the run is bounded
   task automatic tick;
      @(posedge i_sys_clk);
      cyc++;
      if (cyc > 20000) begin
         failures++;
         print_verdict;
      end
   endtask
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= UCD_HTRANS_NONSEQ;
      haddr <= a;
      hwrite <= w;
      do tick; while (hready !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      do tick; while (hready !== 1'b1);
      q = hrdata;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      cmp(q, e);
   endtask
   initial begin
      repeat (10) tick;
      i_reset <= 1'b0;
      tick;
      foreach (rows[i]) begin
         high <= rows[i][20:19];
         kind <= rows[i][18:17];
         bus(1'b1, UCD_CTRL_ADDR, {27'h0, rows[i][16:12]});
         repeat (6) tick;
         cmp({26'h0, sw}, {26'h0, rows[i][11:6]});
         rd(UCD_STAT_ADDR, {26'h0, rows[i][5:0]});
      end
      rd(8'h20, 32'h0);
      bus(1'b1, UCD_MASK_ADDR, 32'h000000F0);
      rd(UCD_MASK_ADDR, 32'h000000F0);
      bus(1'b1, UCD_CTRL_ADDR, 32'h00000010);
      repeat (6) tick;
      cmp({31'h0, usb_int}, 32'h1);
      rd(UCD_EVENT_ADDR, 32'h1);
      rd(UCD_STAT_ADDR, 32'h1);
      cmp({31'h0, usb_int}, 32'h0);
      kind <= 2'h1;
      repeat (2) tick;
      rd(UCD_STAT_ADDR, 32'h0);
      cmp({31'h0, usb_int}, 32'h1);
      rd(UCD_STAT_ADDR, 32'h0);
      bus(1'b1, UCD_MASK_ADDR, 32'h0);
      kind <= 2'h0;
      repeat (6) tick;
      cmp({31'h0, usb_int}, 32'h0);
      vbus <= 1'b1;
      repeat (6) begin
         tick;
         seen += int'(key_int === 1'b1);
      end
      cmp(seen, 32'h1);
      rd(UCD_ANA_ADDR, 32'h1);
      vbus <= 1'b0;
      repeat (4) tick;
      rd(UCD_ANA_ADDR, 32'h0);
      i_reset <= 1'b1;
      repeat (10) tick;
      i_reset <= 1'b0;
      tick;
      cmp({26'h0, sw}, 32'h0);
      rd(UCD_CTRL_ADDR, 32'h0);
      print_verdict;
   end
endmodule
